/* File: hdl/cac_ara_if.sv */
/*
 Link between the alert controller and its alert response responder.
 Assumes one clock for both ends and synchronised scl and sda.
*/
`timescale 1ns/10ps
`default_nettype none
interface cac_ara_if;
   logic       scl;
   logic       sda;
   logic       alert_active;
   logic [6:0] dev_addr;
   logic       sda_drive;
   logic       ara_done;

   modport ctrl (output scl, output sda, output alert_active, output dev_addr,
                 input sda_drive, input ara_done);
   modport resp (input scl, input sda, input alert_active, input dev_addr,
                 output sda_drive, output ara_done);
endinterface
`default_nettype wire

/* File: hdl/cac_ara_responder.sv */
/*
 Alert response responder: while an alert is pending, answers the
 response read with the own address, then pulses ara_done.
 Assumes scl and sda have already passed two flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none
module cac_ara_responder (
   input  wire logic clock_i,
   input  wire logic srst_i,
   cac_ara_if.resp   bus
);
   typedef struct packed {
      cac_pkg::cac_ara_state_t st;
      logic [3:0]              bitcnt;
      logic [7:0]              shreg;
      logic                    scl_q;
      logic                    sda_q;
      logic                    drive;
      logic                    done;
   } cac_resp_t;

   cac_resp_t s;
   cac_resp_t next_s;
   logic      rise;
   logic      fall;
   logic      start;
   logic      stop;

   // Bus edge and framing detection
   assign rise  = bus.scl & ~s.scl_q;
   assign fall  = ~bus.scl & s.scl_q;
   assign start = bus.scl & s.scl_q & s.sda_q & ~bus.sda;
   assign stop  = bus.scl & s.scl_q & ~s.sda_q & bus.sda;

   // Byte framing; sda changes only after scl falls
   always_comb begin
      next_s       = s;
      next_s.done  = 1'b0;
      next_s.scl_q = bus.scl;
      next_s.sda_q = bus.sda;
      if (start) begin
         next_s.st     = cac_pkg::ARA_ADDR_RX;
         next_s.bitcnt = 4'h0;
         next_s.drive  = 1'b0;
      end else if (stop) begin
         next_s.st    = cac_pkg::ARA_IDLE;
         next_s.drive = 1'b0;
      end else begin
         case (s.st)
            cac_pkg::ARA_ADDR_RX: begin
               if (rise) begin
                  next_s.shreg  = {s.shreg[6:0], bus.sda};
                  next_s.bitcnt = s.bitcnt + 4'h1;
                  if (s.bitcnt == 4'h7) begin
                     // Only claim the read while our alert is pending
                     if ({s.shreg[6:0], bus.sda} == {cac_pkg::ARA_ADDR, 1'b1} && bus.alert_active) begin
                        next_s.st = cac_pkg::ARA_ACK;
                     end else begin
                        next_s.st = cac_pkg::ARA_WAIT_STOP;
                     end
                  end
               end
            end
            cac_pkg::ARA_ACK: begin
               if (fall) begin
                  next_s.drive = 1'b1;
                  next_s.st    = cac_pkg::ARA_ACK_HOLD;
               end
            end
            cac_pkg::ARA_ACK_HOLD: begin
               if (fall) begin
                  next_s.shreg  = {bus.dev_addr, 1'b0};
                  next_s.drive  = ~bus.dev_addr[6];
                  next_s.bitcnt = 4'h0;
                  next_s.st     = cac_pkg::ARA_SEND;
               end
            end
            cac_pkg::ARA_SEND: begin
               // A lower address from another device wins the wire
               if (rise && !s.drive && !bus.sda) begin
                  next_s.drive = 1'b0;
                  next_s.st    = cac_pkg::ARA_WAIT_STOP;
               end else if (fall) begin
                  if (s.bitcnt == 4'h7) begin
                     next_s.drive = 1'b0;
                     next_s.st    = cac_pkg::ARA_GET_ACK;
                  end else begin
                     next_s.shreg  = {s.shreg[6:0], 1'b0};
                     next_s.drive  = ~s.shreg[6];
                     next_s.bitcnt = s.bitcnt + 4'h1;
                  end
               end
            end
            cac_pkg::ARA_GET_ACK: begin
               if (rise) begin
                  next_s.done = 1'b1;
                  next_s.st   = cac_pkg::ARA_WAIT_STOP;
               end
            end
            cac_pkg::ARA_IDLE,
            cac_pkg::ARA_WAIT_STOP: begin
               next_s.st = s.st;
            end
            default: begin
               next_s.st = cac_pkg::ARA_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s       <= '0;
         s.scl_q <= 1'b1;
         s.sda_q <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus.sda_drive = s.drive;
   assign bus.ara_done  = s.done;
endmodule
`default_nettype wire

/* File: hdl/cac_pkg.sv */
/*
 Constants, register map and encodings of the charger alert controller.
 Assumes 16-bit words on an 8-bit register address.
*/
package cac_pkg;
   // Register offsets
   localparam logic [7:0] COLD_LIMIT_OFS  = 8'h0B;
   localparam logic [7:0] HOT_LIMIT_OFS   = 8'h0C;
   localparam logic [7:0] LIMIT_EN_OFS    = 8'h0D;
   localparam logic [7:0] CHG_EN_OFS      = 8'h0E;
   localparam logic [7:0] COUNT_OFS       = 8'h20;
   localparam logic [7:0] PRESCALE_OFS    = 8'h21;
   localparam logic [7:0] LOW_LIMIT_OFS   = 8'h22;
   localparam logic [7:0] LIMIT_FLAGS_OFS = 8'h23;
   localparam logic [7:0] CHG_FLAGS_OFS   = 8'h24;
   localparam logic [7:0] CONTROL_OFS     = 8'h25;
   localparam logic [7:0] IRQ_STATUS_OFS  = 8'h26;
   localparam logic [7:0] IRQ_MASK_OFS    = 8'h27;
   localparam logic [7:0] PIN_STATUS_OFS  = 8'h28;

   // Field positions
   localparam int unsigned LOW_CHARGE_BIT = 13;
   localparam int unsigned COLD_BIT       = 1;
   localparam int unsigned HOT_BIT        = 0;
   localparam int unsigned CHG_HALTED_BIT = 8;
   localparam int unsigned COUNT_EN_BIT   = 0;
   localparam int unsigned HALT_BIT       = 1;
   localparam int unsigned IRQ_ALERT_BIT  = 0;
   localparam int unsigned IRQ_ACK_BIT    = 1;
   localparam int unsigned IRQ_BAL_BIT    = 2;
   localparam int unsigned IRQ_FOREIGN_BIT = 3;

   // Writable bit masks and reset values
   localparam logic [15:0] LIMIT_EN_MASK = 16'h2003;
   localparam logic [15:0] CHG_EN_MASK   = 16'h0100;
   localparam logic [15:0] CONTROL_MASK  = 16'h0003;
   localparam logic [15:0] IRQ_MASK_BITS = 16'h000F;
   localparam logic [15:0] LIMIT_EN_RST  = 16'h0000;
   localparam logic [15:0] PRESCALE_RST  = 16'h0001;
   localparam logic [15:0] CONTROL_RST   = 16'h0000;

   // Alert response address (7 bits)
   localparam logic [6:0] ARA_ADDR = 7'h0C;

   // Alert response responder states
   typedef enum logic [2:0] {
      ARA_IDLE      = 3'b000,
      ARA_ADDR_RX   = 3'b001,
      ARA_ACK       = 3'b010,
      ARA_ACK_HOLD  = 3'b011,
      ARA_SEND      = 3'b100,
      ARA_GET_ACK   = 3'b101,
      ARA_WAIT_STOP = 3'b110
   } cac_ara_state_t;
endpackage

/* File: hdl/cac_top.sv */
/*
 Charger alert controller: charge count, limit checks, charger halt,
 open-drain alert line and alert response handling.
 Assumes one-cycle register strobes on clock_i and async bus pins.
*/
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cac_top #(
   parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary own bus address
) (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [15:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [15:0] reg_rdata_o,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        alert_i,
   output logic             alert_o,
   output logic             alert_oe_o,
   input  wire logic        charge_tick_i,
   input  wire logic        charge_dir_i,
   input  wire logic [15:0] ntc_ratio_i,
   input  wire logic        input_power_ok_i,
   input  wire logic        balance_request_pin_i,
   output logic             charge_enable_o,
   output logic             balance_start_o,
   output logic             irq_o
);
   typedef struct packed {
      logic [1:0]  scl_s;
      logic [1:0]  sda_s;
      logic [1:0]  pwr_s;
      logic [1:0]  bal_s;
      logic [1:0]  alr_s;
      logic        bal_q;
      logic [15:0] count;
      logic [15:0] prescale;
      logic [15:0] pre_cnt;
      logic [15:0] low_limit;
      logic [15:0] hot_limit;
      logic [15:0] cold_limit;
      logic [15:0] limit_en;
      logic [15:0] chg_en;
      logic [15:0] limit_flags;
      logic [15:0] chg_flags;
      logic [15:0] control;
      logic [15:0] irq_status;
      logic [15:0] irq_mask;
      logic [15:0] rdata;
      logic        alert;
      logic [1:0]  alert_d;
      logic        charge_en;
      logic        bal_start;
      logic        irq;
   } cac_state_t;

   cac_state_t s;
   cac_state_t next_s;
   logic       ara_done;
   logic       sda_drive;

   cac_ara_if ara ();

   // Write decode, shared by every register
   function automatic logic wr_hit(input logic       wr,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
      wr_hit = wr && (addr == ofs);
   endfunction

   // Read decode; unmapped addresses answer zero
   function automatic logic [15:0] rd_mux(input cac_state_t st,
                                          input logic [7:0] addr);
      case (addr)
         cac_pkg::COLD_LIMIT_OFS:  rd_mux = st.cold_limit;
         cac_pkg::HOT_LIMIT_OFS:   rd_mux = st.hot_limit;
         cac_pkg::LIMIT_EN_OFS:    rd_mux = st.limit_en;
         cac_pkg::CHG_EN_OFS:      rd_mux = st.chg_en;
         cac_pkg::COUNT_OFS:       rd_mux = st.count;
         cac_pkg::PRESCALE_OFS:    rd_mux = st.prescale;
         cac_pkg::LOW_LIMIT_OFS:   rd_mux = st.low_limit;
         cac_pkg::LIMIT_FLAGS_OFS: rd_mux = st.limit_flags;
         cac_pkg::CHG_FLAGS_OFS:   rd_mux = st.chg_flags;
         cac_pkg::CONTROL_OFS:     rd_mux = st.control;
         cac_pkg::IRQ_STATUS_OFS:  rd_mux = st.irq_status;
         cac_pkg::IRQ_MASK_OFS:    rd_mux = st.irq_mask;
         cac_pkg::PIN_STATUS_OFS:  rd_mux = {11'h000, st.alert, st.alr_s[1],
                                               st.charge_en, st.pwr_s[1], st.bal_s[1]};
         default:                  rd_mux = 16'h0000;
      endcase
   endfunction

   // Responder sees only the synchronised pin levels
   assign ara.scl          = s.scl_s[1];
   assign ara.sda          = s.sda_s[1];
   assign ara.alert_active = s.alert;
   assign ara.dev_addr     = DEV_ADDR;
   assign ara_done         = ara.ara_done;
   assign sda_drive        = ara.sda_drive;

   cac_ara_responder u_resp (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .bus     (ara)
   );

   // Next-state logic
   always_comb begin
      logic [15:0] limit_set;
      logic [15:0] new_limit;
      logic [15:0] chg_set;
      logic [15:0] irq_set;
      logic        chg_alert;
      logic        alert_event;
      logic        cnt_step;
      logic        bal_rise;
      logic [15:0] pre_top;

      limit_set   = 16'h0000;
      new_limit   = 16'h0000;
      chg_set     = 16'h0000;
      irq_set     = 16'h0000;
      chg_alert   = 1'b0;
      alert_event = 1'b0;
      cnt_step    = 1'b0;
      bal_rise    = 1'b0;
      pre_top     = 16'h0000;
      next_s      = s;

      // Two flip-flops on the bus, power, balance and alert pins
      next_s.scl_s = {s.scl_s[0], scl_i};
      next_s.sda_s = {s.sda_s[0], sda_i};
      next_s.pwr_s = {s.pwr_s[0], input_power_ok_i};
      next_s.bal_s = {s.bal_s[0], balance_request_pin_i};
      next_s.alr_s = {s.alr_s[0], alert_i};

      // Plain configuration registers
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::COLD_LIMIT_OFS)) begin
         next_s.cold_limit = reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::HOT_LIMIT_OFS)) begin
         next_s.hot_limit = reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::LIMIT_EN_OFS)) begin
         next_s.limit_en = reg_wdata_i & cac_pkg::LIMIT_EN_MASK;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::CHG_EN_OFS)) begin
         next_s.chg_en = reg_wdata_i & cac_pkg::CHG_EN_MASK;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::PRESCALE_OFS)) begin
         next_s.prescale = reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::LOW_LIMIT_OFS)) begin
         next_s.low_limit = reg_wdata_i;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::CONTROL_OFS)) begin
         next_s.control = reg_wdata_i & cac_pkg::CONTROL_MASK;
      end
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::IRQ_MASK_OFS)) begin
         next_s.irq_mask = reg_wdata_i & cac_pkg::IRQ_MASK_BITS;
      end

      // Coulomb counter; a prescale of zero counts like one
      pre_top = (s.prescale == 16'h0000) ? 16'h0000 : s.prescale - 16'h0001;
      if (s.control[cac_pkg::COUNT_EN_BIT] && charge_tick_i) begin
         if (s.pre_cnt >= pre_top) begin
            next_s.pre_cnt = 16'h0000;
            cnt_step       = 1'b1;
         end else begin
            next_s.pre_cnt = s.pre_cnt + 16'h0001;
         end
      end
      if (cnt_step) begin
         // Wraps silently; software picks a prescale that avoids it
         next_s.count = charge_dir_i ? s.count - 16'h0001 : s.count + 16'h0001;
      end
      // Preload wins over a count step in the same cycle
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::COUNT_OFS)) begin
         next_s.count   = reg_wdata_i;
         next_s.pre_cnt = 16'h0000;
      end

      // Limit checks, each gated by its enable
      limit_set[cac_pkg::LOW_CHARGE_BIT] = s.limit_en[cac_pkg::LOW_CHARGE_BIT]
                                           && (s.count < s.low_limit);
      limit_set[cac_pkg::HOT_BIT]  = s.limit_en[cac_pkg::HOT_BIT]
                                     && ($signed(ntc_ratio_i) < $signed(s.hot_limit));
      limit_set[cac_pkg::COLD_BIT] = s.limit_en[cac_pkg::COLD_BIT]
                                     && ($signed(ntc_ratio_i) > $signed(s.cold_limit));
      new_limit = limit_set & ~s.limit_flags;

      // Writing zero clears a flag; a set in the same cycle wins
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::LIMIT_FLAGS_OFS)) begin
         next_s.limit_flags = s.limit_flags & reg_wdata_i;
      end
      next_s.limit_flags = next_s.limit_flags | limit_set;

      // Charger runs only with power present and no halt request
      next_s.charge_en = ~s.control[cac_pkg::HALT_BIT] & s.pwr_s[1];
      chg_set[cac_pkg::CHG_HALTED_BIT] = s.charge_en & ~next_s.charge_en;
      chg_alert = chg_set[cac_pkg::CHG_HALTED_BIT]
                  & s.chg_en[cac_pkg::CHG_HALTED_BIT] & ~s.chg_flags[cac_pkg::CHG_HALTED_BIT];
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::CHG_FLAGS_OFS)) begin
         next_s.chg_flags = s.chg_flags & reg_wdata_i;
      end
      next_s.chg_flags = next_s.chg_flags | chg_set;

      // Alert line: raised by a new event, dropped by acknowledgment
      alert_event = (|new_limit) | chg_alert;
      if (alert_event) begin
         next_s.alert = 1'b1;
      end else if (ara_done) begin
         next_s.alert = 1'b0;
      end

      // Balance pin edge, passed on as one pulse
      next_s.bal_q     = s.bal_s[1];
      bal_rise         = s.bal_s[1] & ~s.bal_q;
      next_s.bal_start = bal_rise;

      // Sticky interrupt status, cleared by writing one
      irq_set[cac_pkg::IRQ_ALERT_BIT]   = alert_event;
      irq_set[cac_pkg::IRQ_ACK_BIT]     = ara_done & s.alert;
      irq_set[cac_pkg::IRQ_BAL_BIT]     = bal_rise;
      next_s.alert_d = {s.alert_d[0], s.alert}; // Pin sync lag
      irq_set[cac_pkg::IRQ_FOREIGN_BIT] = ~s.alr_s[1] & ~s.alert_d[1];
      if (wr_hit(reg_wr_i, reg_addr_i, cac_pkg::IRQ_STATUS_OFS)) begin
         next_s.irq_status = s.irq_status & ~reg_wdata_i;
      end
      next_s.irq_status = next_s.irq_status | irq_set;
      next_s.irq        = |(next_s.irq_status & next_s.irq_mask);

      // Read data stand one cycle after the strobe
      next_s.rdata = reg_rd_i ? rd_mux(s, reg_addr_i) : 16'h0000;
   end

   // Single state register; bus and alert pins idle high through reset
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         s          <= '0;
         s.scl_s    <= 2'h3;
         s.sda_s    <= 2'h3;
         s.alr_s    <= 2'h3;
         s.prescale <= cac_pkg::PRESCALE_RST;
         s.limit_en <= cac_pkg::LIMIT_EN_RST;
         s.control  <= cac_pkg::CONTROL_RST;
      end else begin
         s <= next_s;
      end
   end

   // Open-drain pins only ever pull low
   assign sda_o           = 1'b0;
   assign sda_oe_o        = sda_drive;
   assign alert_o         = 1'b0;
   assign alert_oe_o      = s.alert;
   assign reg_rdata_o     = s.rdata;
   assign charge_enable_o = s.charge_en;
   assign balance_start_o = s.bal_start;
   assign irq_o           = s.irq;
endmodule
`default_nettype wire

/* File: test/cac_smbus_host.sv */
/*
 Serial bus host model: runs the alert response read.
 Assumes the bench resolves the pulled-up data wire into sda_i.
*/
`timescale 1ns/10ps
`default_nettype none
module cac_smbus_host (
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   // Released bus; clock stands high outside frames
   initial {scl_o, sda_low_o} = 2'b10;
   // One 80 ns bit, sampled late in the high phase to allow slow answers
   task automatic bit_cycle(input logic low, output logic seen);
      #10 sda_low_o = low;
      #30 scl_o = 1'b1;
      #38 seen = sda_i;
      #2 scl_o = 1'b0;
   endtask
   // Response read: address byte, one byte back, nack, stop
   task automatic ara_read(output logic ack, output logic [7:0] data);
      logic       s;
      logic [7:0] adr;
      adr = {cac_pkg::ARA_ADDR, 1'b1};
      #3 sda_low_o = 1'b1;
      #40 scl_o = 1'b0;
      for (int i = 7; i >= 0; i--) bit_cycle(!adr[i], s);
      bit_cycle(1'b0, s);
      ack = !s;
      for (int i = 7; i >= 0; i--) bit_cycle(1'b0, data[i]);
      bit_cycle(1'b0, s);
      #10 sda_low_o = 1'b1;
      #30 scl_o = 1'b1;
      #40 sda_low_o = 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: test/cac_top_sva.sv */
/*
 Port checker for the charger alert controller.
 Assumes one clock and synchronous reset; bound to the top.
*/
`timescale 1ns/10ps
`default_nettype none
module cac_top_sva (
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic [7:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        scl_i,
   input wire logic        sda_o,
   input wire logic        alert_o,
   input wire logic        alert_oe_o,
   input wire logic        input_power_ok_i,
   input wire logic        charge_enable_o,
   input wire logic        balance_request_pin_i,
   input wire logic        balance_start_o
);
   // Single domain; reset aborts every attempt
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (srst_i);
   // Enable register written, then read at once
   sequence s_en_wr;
      reg_wr_i && reg_addr_i == cac_pkg::LIMIT_EN_OFS;
   endsequence
   sequence s_en_rd;
      reg_rd_i && reg_addr_i == cac_pkg::LIMIT_EN_OFS;
   endsequence
   property p_en_back;
      s_en_wr ##1 s_en_rd |=> reg_rdata_o == ($past(reg_wdata_i, 2) & cac_pkg::LIMIT_EN_MASK);
   endproperty
   a_en_back: assert property (p_en_back) else $error("enable readback wrong");
   // Read data stands one cycle only
   property p_rd_idle;
      !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   // Open drain: pins only ever pull low
   property p_od;
      sda_o == 1'b0 && alert_o == 1'b0;
   endproperty
   a_od: assert property (p_od) else $error("open drain value high");
   // Outside a frame the clock idles high, so an alert cannot drop
   property p_alert_hold;
      (alert_oe_o && scl_i) [*6] |=> alert_oe_o;
   endproperty
   a_alert_hold: assert property (p_alert_hold) else $error("alert dropped without response read");
   // Halt write stops charging
   property p_halt;
      reg_wr_i && reg_addr_i == cac_pkg::CONTROL_OFS && reg_wdata_i[cac_pkg::HALT_BIT] |-> ##[2:3] !charge_enable_o;
   endproperty
   a_halt: assert property (p_halt) else $error("charging kept after halt");
   // Power loss stops charging
   property p_loss;
      !input_power_ok_i [*4] |-> !charge_enable_o;
   endproperty
   a_loss: assert property (p_loss) else $error("charging kept without power");
   // Halt cleared with power steady resumes charging
   sequence s_resume;
      input_power_ok_i [*4] ##0 (reg_wr_i && reg_addr_i == cac_pkg::CONTROL_OFS && !reg_wdata_i[cac_pkg::HALT_BIT]);
   endsequence
   property p_resume;
      s_resume |=> (input_power_ok_i && !reg_wr_i) [*2] |=> charge_enable_o;
   endproperty
   a_resume: assert property (p_resume) else $error("charging not resumed");
   // Balance pin edge gives a single pulse
   property p_bal;
      $rose(balance_request_pin_i) |-> ##[2:5] balance_start_o ##1 !balance_start_o;
   endproperty
   a_bal: assert property (p_bal) else $error("balance pulse wrong");
endmodule
bind cac_top cac_top_sva u_cac_top_sva (
   .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .sda_o(sda_o),
   .alert_o(alert_o), .alert_oe_o(alert_oe_o), .input_power_ok_i(input_power_ok_i),
   .charge_enable_o(charge_enable_o), .balance_request_pin_i(balance_request_pin_i),
   .balance_start_o(balance_start_o));
`default_nettype wire

/* File: test/test_cac_top.sv */
/*
 Self-checking bench for the charger alert controller.
 Assumes the host model and pull-ups on the data and alert wires.
*/
`timescale 1ns/10ps
`default_nettype none
module test_cac_top;
   localparam logic [6:0] OWN_ADDR = 7'h35; // Arbitrary bus address
   logic        clock_i, srst_i, reg_wr_i, reg_rd_i, scl, host_low, sda_o, sda_oe_o, alert_o, alert_oe_o;
   logic        tick, dir, power_ok, bal_pin, charge_en, bal_start, irq_o;
   logic [7:0]  reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, ntc;
   int          err_total, checks;
   // Pulled-up wires
   wire         sda_w = !(host_low | sda_oe_o);
   wire         alert_w = !alert_oe_o;
   cac_top #(.DEV_ADDR(OWN_ADDR)) u_cac_top (
      .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alert_i(alert_w), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
      .charge_tick_i(tick), .charge_dir_i(dir), .ntc_ratio_i(ntc), .input_power_ok_i(power_ok),
      .balance_request_pin_i(bal_pin), .charge_enable_o(charge_en), .balance_start_o(bal_start),
      .irq_o(irq_o));
   cac_smbus_host u_cac_smbus_host (.sda_i(sda_w), .scl_o(scl), .sda_low_o(host_low));
   // Compare and count
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Register cycles start and end just after a rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 chk(nm, exp, reg_rdata_o);
      @(posedge clock_i);
   endtask
   // Bounded wait for an output level: 0 alert, 1 charging, 2 irq, 3 balance
   task automatic wait_lvl(input string nm, input int sel, input logic lvl);
      logic v;
      for (int n = 0; n < 20; n++) begin
         @(posedge clock_i);
         #1 v = sel == 0 ? alert_oe_o : sel == 1 ? charge_en : sel == 2 ? irq_o : bal_start;
         if (v === lvl) break;
      end
      chk(nm, {15'h0000, lvl}, {15'h0000, v});
      @(posedge clock_i);
   endtask
   // Response read must name us and release the alert
   task automatic ara(input string nm);
      logic       ack;
      logic [7:0] d;
      u_cac_smbus_host.ara_read(ack, d);
      chk("ara_ack", 16'h0001, {15'h0000, ack});
      chk("ara_addr", {8'h00, OWN_ADDR, 1'b0}, {8'h00, d});
      wait_lvl(nm, 0, 1'b0);
   endtask
   task automatic t_reset();
      rd(cac_pkg::LIMIT_EN_OFS, 16'h0000, "limit_en");
      rd(cac_pkg::PRESCALE_OFS, 16'h0001, "prescale");
      wr(8'h30, 16'hFFFF);
      rd(8'h30, 16'h0000, "unmapped");
      // Write, then read at once; cold left off
      reg_addr_i <= cac_pkg::LIMIT_EN_OFS;
      reg_wdata_i <= 16'hFFFD;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
      rd(cac_pkg::LIMIT_EN_OFS, cac_pkg::LIMIT_EN_MASK & 16'hFFFD, "en_mask");
      wr(cac_pkg::LIMIT_EN_OFS, 16'h0000);
   endtask
   task automatic t_low();
      wr(cac_pkg::COUNT_OFS, 16'h0005);
      wr(cac_pkg::PRESCALE_OFS, 16'h0002);
      wr(cac_pkg::LOW_LIMIT_OFS, 16'h0004);
      wr(cac_pkg::CONTROL_OFS, 16'h0001);
      // Four discharge ticks at prescale two
      repeat (4) begin
         tick <= 1'b1;
         @(posedge clock_i);
         tick <= 1'b0;
         @(posedge clock_i);
      end
      rd(cac_pkg::COUNT_OFS, 16'h0003, "count");
      rd(cac_pkg::LIMIT_FLAGS_OFS, 16'h0000, "flag_gated");
      wr(cac_pkg::LIMIT_EN_OFS, 16'h2000);
      wait_lvl("alert_low", 0, 1'b1);
      ara("rel_low");
      rd(cac_pkg::LIMIT_FLAGS_OFS, 16'h2000, "flag_kept");
      wr(cac_pkg::COUNT_OFS, 16'h0100);
      wr(cac_pkg::LIMIT_FLAGS_OFS, 16'h0000);
      rd(cac_pkg::LIMIT_FLAGS_OFS, 16'h0000, "flag_clr");
   endtask
   task automatic t_temp();
      wr(cac_pkg::HOT_LIMIT_OFS, 16'h0010);
      wr(cac_pkg::COLD_LIMIT_OFS, 16'h0100);
      wr(cac_pkg::LIMIT_EN_OFS, 16'h0003);
      ntc <= 16'hFE00; // Negative: below the limit only when signed
      wait_lvl("alert_hot", 0, 1'b1);
      ntc <= 16'h0050;
      ara("rel_hot");
      ntc <= 16'h0200;
      wait_lvl("alert_cold", 0, 1'b1);
      ntc <= 16'h0050;
      ara("rel_cold");
      rd(cac_pkg::LIMIT_FLAGS_OFS, 16'h0003, "both_flags");
      wr(cac_pkg::LIMIT_FLAGS_OFS, 16'h0002);
      rd(cac_pkg::LIMIT_FLAGS_OFS, 16'h0002, "hot_clr");
      wr(cac_pkg::LIMIT_EN_OFS, 16'h0000);
   endtask
   task automatic t_chg();
      wr(cac_pkg::CONTROL_OFS, 16'h0002);
      wait_lvl("chg_halt", 1, 1'b0);
      rd(cac_pkg::CHG_FLAGS_OFS, 16'h0100, "halted");
      wr(cac_pkg::CHG_FLAGS_OFS, 16'h0000);
      wr(cac_pkg::CHG_EN_OFS, 16'h0100);
      wr(cac_pkg::CONTROL_OFS, 16'h0000);
      wait_lvl("chg_resume", 1, 1'b1);
      power_ok <= 1'b0;
      wait_lvl("chg_loss", 1, 1'b0);
      wait_lvl("alert_loss", 0, 1'b1);
      rd(cac_pkg::CHG_FLAGS_OFS, 16'h0100, "halted_loss");
      ara("rel_loss");
      power_ok <= 1'b1;
      wait_lvl("chg_back", 1, 1'b1);
   endtask
   task automatic t_irq();
      wait_lvl("irq_masked", 2, 1'b0);
      wr(cac_pkg::IRQ_MASK_OFS, 16'h000A);
      wait_lvl("irq_ack", 2, 1'b1);
      wr(cac_pkg::IRQ_STATUS_OFS, 16'h0002);
      wait_lvl("irq_clr", 2, 1'b0);
      wr(cac_pkg::IRQ_MASK_OFS, 16'h0004);
      bal_pin <= 1'b1;
      wait_lvl("bal_pulse", 3, 1'b1);
      wait_lvl("irq_bal", 2, 1'b1);
      wr(cac_pkg::IRQ_STATUS_OFS, 16'h000F);
      wait_lvl("irq_done", 2, 1'b0);
   endtask
   task automatic end_sim();
      if (err_total == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // 100 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // Watchdog well beyond the run length
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
   // Reset for four cycles, then the scenarios
   initial begin
      {srst_i, reg_wr_i, reg_rd_i, tick, dir, power_ok, bal_pin} = 7'b1000110;
      reg_addr_i = 8'h00;
      reg_wdata_i = 16'h0000;
      ntc = 16'h0050;
      repeat (4) @(posedge clock_i);
      srst_i <= 1'b0;
      @(posedge clock_i);
      t_reset();
      t_low();
      t_temp();
      t_chg();
      t_irq();
      end_sim();
   end
endmodule
`default_nettype wire
